// ---- hw/scm_channel.sv ----
// One asynchronous serial channel with its mode, control and port registers behind APB.
//
// Behaviour
// - A set mask bit lets its interrupt source drive the request output.
// - The timer preload is 16 bits, upper register high byte, lower register low.
// - Input port bit 7 always reads one.
// - Input port bit 6 reads acknowledge level, bits 5 to 0 the input pins.
// - Mode pointer starts at register one, moves to two after any access.
// - Ready-to-receive drops on start bit with full FIFO, returns when space frees.
// - Receive interrupt source is receiver ready or FIFO full; also drives output four.
// - Character mode shows top errors; block mode ORs them until error reset.
// - With or force parity adds and checks a parity bit; 11 means multidrop.
// - Parity type picks odd/even, forced level or address tag.
// - Bits-per-character sets data bits, excluding start, parity and stop.
// - Normal mode runs transmitter and receiver independently.
// - Echo mode resends received line; transmitter flags and writes disabled.
// - Echo resends parity, stop and break as received, still checking them.
// - Local loopback feeds transmitter to receiver; line output held high.
// - Remote loopback resends line; data unreadable and errors inactive.
// - Auto request-to-send clears output bit 0 one bit after idle and disabled.
// - A disabled transmitter shows ready and empty flags inactive.
// - A held character is still sent after the transmitter is disabled.
// - With clear-to-send control, a character starts only while input zero is low.
// - One, one-and-a-half or two stop bits sent; receiver checks only first.
// - Stop code 00 and 01 give one, 10 one-and-a-half, 11 two stop bits.
// - Parity code 00 with, 01 force, 10 none, 11 multidrop.
`timescale 1ns/1ps
`default_nettype none

module scm_channel
	import scm_pkg::*;
#(
	parameter int HALF_BIT_CYC = DEF_HALF_BIT,
	parameter int FIFO_DEPTH   = DEF_FIFO_DEPTH
) (
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        rxdPin,
	input  wire logic [5:0]  inPins,
	input  wire logic        iackPin,
	output var  logic        txdPin,
	output var  logic        outZeroN,
	output var  logic        outFourN,
	output var  logic        irqN,
	output var  logic [15:0] timerPreload,
	output var  logic [7:0]  intVector
);

	localparam int CW = $clog2(FIFO_DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT  = CW'(FIFO_DEPTH);
	localparam logic [15:0]   HALF_LAST = 16'(HALF_BIT_CYC - 1);
	localparam logic [15:0]   BIT_LAST  = 16'(2 * HALF_BIT_CYC - 1);
	localparam logic [15:0]   STOP1_LAST = BIT_LAST;
	localparam logic [15:0]   STOP15_LAST = 16'(3 * HALF_BIT_CYC - 1);
	localparam logic [15:0]   STOP2_LAST = 16'(4 * HALF_BIT_CYC - 1);

	generate
		if (HALF_BIT_CYC < 1 || HALF_BIT_CYC > 8000 || FIFO_DEPTH < 2 || FIFO_DEPTH > 64) begin : g_chk
			$error("scm_channel: unsupported HALF_BIT_CYC or FIFO_DEPTH");
		end
	endgenerate

	// Pins cross into mclk through two flops; bit 7 rxd, bit 6 acknowledge, 5:0 inputs.
	logic [7:0] inS1Q;
	logic [7:0] inS2Q;
	logic       ctsN;
	logic       iackLvl;
	logic       rxdLine;

	logic [7:0]  mr1Q, mr1D, mr2Q, mr2D, maskQ, maskD, preUpQ, preUpD;
	logic [7:0]  preLoQ, preLoD, vecQ, vecD, outPortQ, outPortD, outCfgQ, outCfgD;
	logic        ptrQ, ptrD, txEnQ, txEnD, rxEnQ, rxEnD;
	logic        preadyQ, preadyD, slvErrQ, slvErrD;
	logic [31:0] prdataQ, prdataD;
	logic        txdQ, txdD, zeroNQ, zeroND, fourNQ, fourND, irqNQ, irqND;

	logic        acc, wr, cmdWr, thrWr, rxPop, rxReset, txReset, errReset;
	logic [2:0]  misc;
	logic [1:0]  chMode;
	logic        notEcho;
	logic [7:0]  statusByte, intStat;
	logic        transmitter_ready_flag, transmitter_empty_flag, receiver_ready_flag, fifo_full_flag, rxIntSrc;

	scm_tx_state_t txStQ, txStD;
	logic [15:0] txCntQ, txCntD, rtsCntQ, rtsCntD, stopLast;
	logic [2:0]  txBitQ, txBitD;
	logic [7:0]  txShQ, txShD, thrQ, thrD;
	logic        txParQ, txParD, txLineQ, txLineD, thrFullQ, thrFullD;
	logic [1:0]  txLenQ, txLenD, txStopQ, txStopD;
	logic        txParEnQ, txParEnD, rtsArm, rtsClear;
	logic [1:0]  pm;
	logic        ptype;

	scm_rx_state_t rxStQ, rxStD;
	logic [15:0] rxCntQ, rxCntD;
	logic [2:0]  rxBitQ, rxBitD;
	logic [7:0]  rxShQ, rxShD, rxData;
	logic        rxParQ, rxParD, rxIn, rxZero;
	logic [10:0] memQ [FIFO_DEPTH];
	logic [10:0] memD [FIFO_DEPTH];
	logic [CW-1:0] cntQ, cntD;
	logic [2:0]  blkQ, blkD, errShow;
	logic        ovrQ, ovrD, rtrNegQ, rtrNegD;
	logic [10:0] entry;
	logic        push;

	assign ctsN    = inS2Q[0];
	assign iackLvl = inS2Q[6];
	assign rxdLine = inS2Q[7];
	assign chMode  = mr2Q[M2_CH_LSB +: 2];
	assign notEcho = (chMode != CH_ECHO);
	assign pm      = mr1Q[M1_PAR_LSB +: 2];
	assign ptype   = mr1Q[M1_PTYPE];

	assign prdata       = prdataQ;
	assign pready       = preadyQ;
	assign pslverr      = slvErrQ;
	assign txdPin       = txdQ;
	assign outZeroN     = zeroNQ;
	assign outFourN     = fourNQ;
	assign irqN         = irqNQ;
	assign timerPreload = {preUpQ, preLoQ};
	assign intVector    = vecQ;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			inS1Q <= 8'hff;
			inS2Q <= 8'hff;
		end else begin
			inS1Q <= {rxdPin, iackPin, inPins};
			inS2Q <= inS1Q;
		end
	end

	// Status seen by software and by the output pins.
	assign transmitter_ready_flag    = txEnQ && !thrFullQ && notEcho;
	assign transmitter_empty_flag    = transmitter_ready_flag && (txStQ == TX_IDLE);
	assign receiver_ready_flag    = (cntQ != '0);
	assign fifo_full_flag    = (cntQ == FULL_CNT);
	assign rxIntSrc = mr1Q[M1_RXSEL] ? fifo_full_flag : receiver_ready_flag;
	assign errShow  = mr1Q[M1_BLOCK] ? blkQ : (receiver_ready_flag ? memQ[0][10:8] : 3'h0);
	assign statusByte = {errShow, ovrQ, transmitter_empty_flag, transmitter_ready_flag, fifo_full_flag, receiver_ready_flag};
	assign intStat  = {6'h00, rxIntSrc, transmitter_ready_flag};

	// APB decode: one wait state, writes and side effects on the completing edge.
	assign acc      = psel && penable && preadyQ;
	assign wr       = acc && pwrite;
	assign cmdWr    = wr && (paddr == ADDR_CMD);
	assign misc     = pwdata[CMD_MSC_LSB +: 3];
	assign rxReset  = cmdWr && (misc == MSC_RX);
	assign txReset  = cmdWr && (misc == MSC_TX);
	assign errReset = cmdWr && (misc == MSC_ERR);
	assign thrWr    = wr && (paddr == ADDR_DATA);
	assign rxPop    = acc && !pwrite && (paddr == ADDR_DATA);

	always_comb begin
		mr1D     = mr1Q;
		mr2D     = mr2Q;
		ptrD     = ptrQ;
		maskD    = maskQ;
		preUpD   = preUpQ;
		preLoD   = preLoQ;
		vecD     = vecQ;
		outPortD = outPortQ;
		outCfgD  = outCfgQ;
		txEnD    = txEnQ;
		rxEnD    = rxEnQ;
		if (acc && (paddr == ADDR_MODE)) begin
			if (pwrite && !ptrQ) begin
				mr1D = pwdata[7:0];
			end else if (pwrite) begin
				mr2D = pwdata[7:0];
			end
			ptrD = 1'b1;
		end
		if (cmdWr && (misc == MSC_PTR)) begin
			ptrD = 1'b0;
		end
		if (cmdWr && (pwdata[CMD_TX_LSB +: 2] == CMD_ON)) begin
			txEnD = 1'b1;
		end else if (cmdWr && (pwdata[CMD_TX_LSB +: 2] == CMD_OFF)) begin
			txEnD = 1'b0;
		end
		if (txReset) begin
			txEnD = 1'b0;
		end
		if (cmdWr && (pwdata[CMD_RX_LSB +: 2] == CMD_ON)) begin
			rxEnD = 1'b1;
		end else if (cmdWr && (pwdata[CMD_RX_LSB +: 2] == CMD_OFF)) begin
			rxEnD = 1'b0;
		end
		if (rxReset) begin
			rxEnD = 1'b0;
		end
		if (rtsClear) begin
			outPortD[0] = 1'b0;
		end
		if (wr) begin
			unique case (paddr)
				ADDR_INT_MASK:   maskD    = pwdata[7:0];
				ADDR_PRELOAD_UP: preUpD   = pwdata[7:0];
				ADDR_PRELOAD_LO: preLoD   = pwdata[7:0];
				ADDR_VECTOR:     vecD     = pwdata[7:0];
				ADDR_OUT_PORT:   outPortD = pwdata[7:0];
				ADDR_OUT_CFG:    outCfgD  = pwdata[7:0];
				default:         ;
			endcase
		end
		preadyD = psel && penable && !preadyQ;
		prdataD = 32'h0;
		slvErrD = 1'b0;
		if (preadyD && !pwrite) begin
			unique case (paddr)
				ADDR_MODE:       prdataD[7:0] = ptrQ ? mr2Q : mr1Q;
				ADDR_STATUS:     prdataD[7:0] = statusByte;
				ADDR_CMD:        prdataD[7:0] = 8'h00;
				ADDR_DATA:       prdataD[7:0] = memQ[0][7:0];
				ADDR_INT_MASK:   prdataD[7:0] = maskQ;
				ADDR_PRELOAD_UP: prdataD[7:0] = preUpQ;
				ADDR_PRELOAD_LO: prdataD[7:0] = preLoQ;
				ADDR_VECTOR:     prdataD[7:0] = vecQ;
				ADDR_INPUT:      prdataD[7:0] = {1'b1, iackLvl, inS2Q[5:0]};
				ADDR_OUT_PORT:   prdataD[7:0] = outPortQ;
				ADDR_OUT_CFG:    prdataD[7:0] = outCfgQ;
				ADDR_INT_STAT:   prdataD[7:0] = intStat;
				default:         slvErrD = 1'b1;
			endcase
		end else if (preadyD) begin
			slvErrD = !(paddr inside {ADDR_MODE, ADDR_CMD, ADDR_DATA, ADDR_INT_MASK,
				ADDR_PRELOAD_UP, ADDR_PRELOAD_LO, ADDR_VECTOR, ADDR_OUT_PORT, ADDR_OUT_CFG});
		end
		irqND  = ~|(intStat & maskQ);
		fourND = outCfgQ[CFG_OUT4] ? !rxIntSrc : !outPortQ[4];
		zeroND = !(outPortQ[0] && !(mr1Q[M1_RTR] && rtrNegQ));
		unique case (chMode)
			CH_LOCAL:  txdD = 1'b1;
			CH_ECHO:   txdD = rxdLine;
			CH_REMOTE: txdD = rxdLine;
			default:   txdD = txLineQ;
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mr1Q     <= REG_RST;
			mr2Q     <= REG_RST;
			ptrQ     <= 1'b0;
			maskQ    <= REG_RST;
			preUpQ   <= REG_RST;
			preLoQ   <= REG_RST;
			vecQ     <= REG_RST;
			outPortQ <= REG_RST;
			outCfgQ  <= REG_RST;
			txEnQ    <= 1'b0;
			rxEnQ    <= 1'b0;
			preadyQ  <= 1'b0;
			prdataQ  <= 32'h0;
			slvErrQ  <= 1'b0;
			txdQ     <= 1'b1;
			zeroNQ   <= 1'b1;
			fourNQ   <= 1'b1;
			irqNQ    <= 1'b1;
		end else begin
			mr1Q     <= mr1D;
			mr2Q     <= mr2D;
			ptrQ     <= ptrD;
			maskQ    <= maskD;
			preUpQ   <= preUpD;
			preLoQ   <= preLoD;
			vecQ     <= vecD;
			outPortQ <= outPortD;
			outCfgQ  <= outCfgD;
			txEnQ    <= txEnD;
			rxEnQ    <= rxEnD;
			preadyQ  <= preadyD;
			prdataQ  <= prdataD;
			slvErrQ  <= slvErrD;
			txdQ     <= txdD;
			zeroNQ   <= zeroND;
			fourNQ   <= fourND;
			irqNQ    <= irqND;
		end
	end

	// Transmitter: holding register, shifter and the request-to-send timer.
	assign rtsArm   = mr2Q[M2_RTS] && !txEnQ && (txStQ == TX_IDLE) && !thrFullQ && outPortQ[0];
	assign rtsClear = rtsArm && (rtsCntQ == BIT_LAST);

	always_comb begin
		txStD    = txStQ;
		txCntD   = txCntQ + 16'h1;
		txBitD   = txBitQ;
		txShD    = txShQ;
		txParD   = txParQ;
		txLineD  = txLineQ;
		thrD     = thrQ;
		thrFullD = thrFullQ;
		txLenD   = txLenQ;
		txStopD  = txStopQ;
		txParEnD = txParEnQ;
		rtsCntD  = rtsArm ? rtsCntQ + 16'h1 : 16'h0;
		unique case (txStopQ)
			STOP_ONE_HALF: stopLast = STOP15_LAST;
			STOP_TWO:      stopLast = STOP2_LAST;
			default:       stopLast = STOP1_LAST;
		endcase
		unique case (txStQ)
			TX_IDLE: begin
				txCntD = 16'h0;
				if (thrFullQ && (!mr2Q[M2_CTS] || !ctsN)) begin
					txShD    = thrQ & (8'hff >> (2'h3 - mr1Q[M1_BPC_LSB +: 2]));
					thrFullD = 1'b0;
					txLenD   = mr1Q[M1_BPC_LSB +: 2];
					txStopD  = mr2Q[M2_STOP_LSB +: 2];
					txParEnD = (pm != PAR_NONE);
					txParD   = (pm == PAR_WITH) ? ^(thrQ & (8'hff >> (2'h3 - mr1Q[M1_BPC_LSB +: 2]))) ^ ptype
						: ptype;
					txLineD  = 1'b0;
					txStD    = TX_START;
				end
			end
			TX_START: begin
				if (txCntQ == BIT_LAST) begin
					txCntD  = 16'h0;
					txBitD  = 3'h0;
					txLineD = txShQ[0];
					txShD   = txShQ >> 1;
					txStD   = TX_DATA;
				end
			end
			TX_DATA: begin
				if (txCntQ == BIT_LAST) begin
					txCntD = 16'h0;
					if (txBitQ == ({1'b0, txLenQ} + 3'h4)) begin
						txLineD = txParEnQ ? txParQ : 1'b1;
						txStD   = txParEnQ ? TX_PAR : TX_STOP;
					end else begin
						txBitD  = txBitQ + 3'h1;
						txLineD = txShQ[0];
						txShD   = txShQ >> 1;
					end
				end
			end
			TX_PAR: begin
				if (txCntQ == BIT_LAST) begin
					txCntD  = 16'h0;
					txLineD = 1'b1;
					txStD   = TX_STOP;
				end
			end
			TX_STOP: begin
				if (txCntQ == stopLast) begin
					txStD = TX_IDLE;
				end
			end
			default: txStD = TX_IDLE;
		endcase
		if (thrWr && txEnQ && notEcho && !thrFullQ) begin
			thrD     = pwdata[7:0];
			thrFullD = 1'b1;
		end
		if (txReset) begin
			txStD    = TX_IDLE;
			thrFullD = 1'b0;
			txLineD  = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			txStQ    <= TX_IDLE;
			txCntQ   <= 16'h0;
			txBitQ   <= 3'h0;
			txShQ    <= 8'h00;
			txParQ   <= 1'b0;
			txLineQ  <= 1'b1;
			thrQ     <= 8'h00;
			thrFullQ <= 1'b0;
			txLenQ   <= 2'h0;
			txStopQ  <= 2'h0;
			txParEnQ <= 1'b0;
			rtsCntQ  <= 16'h0;
		end else begin
			txStQ    <= txStD;
			txCntQ   <= txCntD;
			txBitQ   <= txBitD;
			txShQ    <= txShD;
			txParQ   <= txParD;
			txLineQ  <= txLineD;
			thrQ     <= thrD;
			thrFullQ <= thrFullD;
			txLenQ   <= txLenD;
			txStopQ  <= txStopD;
			txParEnQ <= txParEnD;
			rtsCntQ  <= rtsCntD;
		end
	end

	// Receiver, its FIFO and the error and flow-control flags.
	assign rxIn   = (chMode == CH_LOCAL) ? txLineQ : rxdLine;
	assign rxData = rxShQ >> (2'h3 - mr1Q[M1_BPC_LSB +: 2]);
	assign rxZero = (rxData == 8'h00) && !(rxParQ && pm != PAR_NONE);

	always_comb begin
		rxStD   = rxStQ;
		rxCntD  = rxCntQ + 16'h1;
		rxBitD  = rxBitQ;
		rxShD   = rxShQ;
		rxParD  = rxParQ;
		rtrNegD = rtrNegQ && (cntQ == FULL_CNT);
		push    = 1'b0;
		entry   = {3'h0, rxData};
		unique case (rxStQ)
			RX_IDLE: begin
				rxCntD = 16'h0;
				if (rxEnQ && !rxIn) begin
					rxStD = RX_START;
				end
			end
			RX_START: begin
				if (rxCntQ == HALF_LAST) begin
					rxCntD = 16'h0;
					rxBitD = 3'h0;
					rxParD = 1'b0;
					rxStD  = rxIn ? RX_IDLE : RX_DATA;
					if (!rxIn && fifo_full_flag && mr1Q[M1_RTR]) begin
						rtrNegD = 1'b1;
					end
				end
			end
			RX_DATA: begin
				if (rxCntQ == BIT_LAST) begin
					rxCntD = 16'h0;
					rxShD  = {rxIn, rxShQ[7:1]};
					rxBitD = rxBitQ + 3'h1;
					if (rxBitQ == ({1'b0, mr1Q[M1_BPC_LSB +: 2]} + 3'h4)) begin
						rxStD = (pm == PAR_NONE) ? RX_STOP : RX_PAR;
					end
				end
			end
			RX_PAR: begin
				if (rxCntQ == BIT_LAST) begin
					rxCntD = 16'h0;
					rxParD = rxIn;
					rxStD  = RX_STOP;
				end
			end
			RX_STOP: begin
				if (rxCntQ == BIT_LAST) begin
					push     = (chMode != CH_REMOTE);
					entry[10] = rxZero && !rxIn;
					entry[9]  = !rxIn;
					unique case (pm)
						PAR_WITH:  entry[8] = ^rxData ^ rxParQ ^ ptype;
						PAR_FORCE: entry[8] = rxParQ ^ ptype;
						PAR_MDROP: entry[8] = rxParQ;
						default:   entry[8] = 1'b0;
					endcase
					rxStD = (rxZero && !rxIn) ? RX_BRK : RX_IDLE;
				end
			end
			RX_BRK: begin
				if (rxIn) begin
					rxStD = RX_IDLE;
				end
			end
			default: rxStD = RX_IDLE;
		endcase
		for (int i = 0; i < FIFO_DEPTH; i++) begin
			memD[i] = memQ[i];
		end
		cntD = cntQ;
		ovrD = ovrQ && !errReset;
		if (rxPop && receiver_ready_flag) begin
			for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
				memD[i] = memQ[i + 1];
			end
			memD[FIFO_DEPTH - 1] = 11'h000;
			cntD = cntQ - CW'(1);
		end
		if (push && cntD != FULL_CNT) begin
			memD[cntD] = entry;
			cntD       = cntD + CW'(1);
		end else if (push) begin
			ovrD = 1'b1;
		end
		blkD = (errReset ? 3'h0 : blkQ) | (receiver_ready_flag ? memQ[0][10:8] : 3'h0);
		if (rxReset) begin
			rxStD   = RX_IDLE;
			cntD    = '0;
			rtrNegD = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rxStQ   <= RX_IDLE;
			rxCntQ  <= 16'h0;
			rxBitQ  <= 3'h0;
			rxShQ   <= 8'h00;
			rxParQ  <= 1'b0;
			cntQ    <= '0;
			blkQ    <= 3'h0;
			ovrQ    <= 1'b0;
			rtrNegQ <= 1'b0;
			for (int i = 0; i < FIFO_DEPTH; i++) begin
				memQ[i] <= 11'h000;
			end
		end else begin
			rxStQ   <= rxStD;
			rxCntQ  <= rxCntD;
			rxBitQ  <= rxBitD;
			rxShQ   <= rxShD;
			rxParQ  <= rxParD;
			cntQ    <= cntD;
			blkQ    <= blkD;
			ovrQ    <= ovrD;
			rtrNegQ <= rtrNegD;
			for (int i = 0; i < FIFO_DEPTH; i++) begin
				memQ[i] <= memD[i];
			end
		end
	end

endmodule : scm_channel

`default_nettype wire

// ---- common/scm_pkg.sv ----
// Shared constants, encodings and state types of the serial channel mode control block.
package scm_pkg;

	localparam logic [7:0] ADDR_MODE       = 8'h00;
	localparam logic [7:0] ADDR_STATUS     = 8'h04;
	localparam logic [7:0] ADDR_CMD        = 8'h08;
	localparam logic [7:0] ADDR_DATA       = 8'h0c;
	localparam logic [7:0] ADDR_INT_MASK   = 8'h10;
	localparam logic [7:0] ADDR_PRELOAD_UP = 8'h14;
	localparam logic [7:0] ADDR_PRELOAD_LO = 8'h18;
	localparam logic [7:0] ADDR_VECTOR     = 8'h1c;
	localparam logic [7:0] ADDR_INPUT      = 8'h20;
	localparam logic [7:0] ADDR_OUT_PORT   = 8'h24;
	localparam logic [7:0] ADDR_OUT_CFG    = 8'h28;
	localparam logic [7:0] ADDR_INT_STAT   = 8'h2c;

	localparam int M1_RTR      = 7;
	localparam int M1_RXSEL    = 6;
	localparam int M1_BLOCK    = 5;
	localparam int M1_PAR_LSB  = 3;
	localparam int M1_PTYPE    = 2;
	localparam int M1_BPC_LSB  = 0;
	localparam int M2_CH_LSB   = 6;
	localparam int M2_RTS      = 5;
	localparam int M2_CTS      = 4;
	localparam int M2_STOP_LSB = 2;
	localparam int CMD_RX_LSB  = 0;
	localparam int CMD_TX_LSB  = 2;
	localparam int CMD_MSC_LSB = 4;
	localparam int CFG_OUT4    = 4;

	localparam logic [1:0] PAR_WITH  = 2'h0;
	localparam logic [1:0] PAR_FORCE = 2'h1;
	localparam logic [1:0] PAR_NONE  = 2'h2;
	localparam logic [1:0] PAR_MDROP = 2'h3;
	localparam logic [1:0] CH_NORMAL = 2'h0;
	localparam logic [1:0] CH_ECHO   = 2'h1;
	localparam logic [1:0] CH_LOCAL  = 2'h2;
	localparam logic [1:0] CH_REMOTE = 2'h3;
	localparam logic [1:0] STOP_ONE_HALF = 2'h2;
	localparam logic [1:0] STOP_TWO  = 2'h3;
	localparam logic [1:0] CMD_ON    = 2'h1;
	localparam logic [1:0] CMD_OFF   = 2'h2;
	localparam logic [2:0] MSC_PTR   = 3'h1;
	localparam logic [2:0] MSC_RX    = 3'h2;
	localparam logic [2:0] MSC_TX    = 3'h3;
	localparam logic [2:0] MSC_ERR   = 3'h4;

	localparam logic [7:0] REG_RST      = 8'h00;
	localparam int         CLK_PERIOD_NS = 100;
	localparam int         DEF_HALF_BIT = 8;
	localparam int         DEF_FIFO_DEPTH = 3;

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} scm_tx_state_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK} scm_rx_state_t;

endpackage : scm_pkg

// ---- dv/scm_channel_assertions.sv ----
// Checker of the serial channel block, attached to every instance by bind.
`timescale 1ns/1ps
`default_nettype none
module scm_channel_assertions
	import scm_pkg::*;
#(
	parameter int HALF_BIT_CYC = DEF_HALF_BIT
) (
	input wire logic        mclk,
	input wire logic        arst_n,
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [5:0]  inPins,
	input wire logic        iackPin,
	input wire logic        txdPin,
	input wire logic        irqN,
	input wire logic [15:0] timerPreload
);
	localparam int LIM = 24 * HALF_BIT_CYC + 8;
	logic       acc;
	logic       wrA;
	logic       rdA;
	logic       ptrQ;
	logic       txOnQ;
	logic [7:0] m2Q;
	int         ctsQ;
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	assign acc = psel && penable && pready && !pslverr;
	assign wrA = acc && pwrite;
	assign rdA = psel && penable && pready && !pwrite;
	// Shadow of the second mode register and transmitter enable, seen from the bus.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ptrQ <= 1'b0;
			txOnQ <= 1'b0;
			m2Q <= 8'h00;
			ctsQ <= 0;
		end else begin
			if (acc && paddr == ADDR_MODE) begin
				ptrQ <= 1'b1;
				if (ptrQ && pwrite) m2Q <= pwdata[7:0];
			end
			if (wrA && paddr == ADDR_CMD) begin
				if (pwdata[6:4] == MSC_PTR) ptrQ <= 1'b0;
				if (pwdata[3:2] == CMD_ON) txOnQ <= 1'b1;
				if (pwdata[3:2] == CMD_OFF || pwdata[6:4] == MSC_TX) txOnQ <= 1'b0;
			end
			if (m2Q[M2_CTS] && inPins[0] && m2Q[7:6] == CH_NORMAL) begin
				ctsQ <= (ctsQ == LIM) ? LIM : ctsQ + 1;
			end else begin
				ctsQ <= 0;
			end
		end
	end
	property p_mask_off;
		wrA && paddr == ADDR_INT_MASK && pwdata[7:0] == 8'h00 |-> ##3 irqN [*4];
	endproperty
	a_mask_off: assert property (p_mask_off) else $error("irq low with all masked");
	property p_upper;
		wrA && paddr == ADDR_PRELOAD_UP |=> timerPreload[15:8] == $past(pwdata[7:0]);
	endproperty
	a_upper: assert property (p_upper) else $error("upper preload byte wrong");
	property p_lower;
		wrA && paddr == ADDR_PRELOAD_LO |=> timerPreload[7:0] == $past(pwdata[7:0]);
	endproperty
	a_lower: assert property (p_lower) else $error("lower preload byte wrong");
	property p_bit7;
		rdA && paddr == ADDR_INPUT |-> prdata[7];
	endproperty
	a_bit7: assert property (p_bit7) else $error("input port bit 7 not one");
	property p_pins;
		($stable(iackPin) && $stable(inPins)) [*5] ##0 (rdA && paddr == ADDR_INPUT)
			|-> prdata[6:0] == {iackPin, inPins};
	endproperty
	a_pins: assert property (p_pins) else $error("input port levels wrong");
	property p_loop;
		(m2Q[7:6] == CH_LOCAL) [*3] |-> txdPin;
	endproperty
	a_loop: assert property (p_loop) else $error("line low in local loopback");
	property p_txflags;
		rdA && paddr == ADDR_STATUS && (!txOnQ || m2Q[7:6] == CH_ECHO) |-> prdata[3:2] == 2'b00;
	endproperty
	a_txflags: assert property (p_txflags) else $error("transmit flags active");
	property p_cts;
		ctsQ == LIM |-> txdPin;
	endproperty
	a_cts: assert property (p_cts) else $error("sent while clear-to-send high");
	c_cts: cover property (ctsQ == LIM);
	c_loop: cover property (m2Q[7:6] == CH_LOCAL && rdA);
	c_irq: cover property (!irqN);
endmodule : scm_channel_assertions
bind scm_channel scm_channel_assertions #(.HALF_BIT_CYC(HALF_BIT_CYC)) i_chk (
	.mclk, .arst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
	.pslverr, .inPins, .iackPin, .txdPin, .irqN, .timerPreload
);
`default_nettype wire

// ---- dv/scm_remote_model.sv ----
// Remote serial device: drives the channel's receive line and captures its transmit line.
`timescale 1ns/1ps
`default_nettype none
module scm_remote_model #(
	parameter int HB = 2
) (
	input  wire logic mclk,
	output var  logic rxd,
	input  wire logic txd
);
	initial rxd = 1'b1;
	// Sends one character without parity and with one stop bit, low bit first.
	task automatic send(input logic [7:0] d, input int nb);
		@(posedge mclk);
		rxd <= 1'b0;
		repeat (2 * HB) @(posedge mclk);
		for (int i = 0; i < nb; i++) begin
			rxd <= d[i];
			repeat (2 * HB) @(posedge mclk);
		end
		rxd <= 1'b1;
		repeat (2 * HB) @(posedge mclk);
	endtask : send
	// Waits a bounded time for a start bit, then samples twelve bit centres after it.
	task automatic getc(output logic [11:0] f, output logic ok);
		int n;
		f = 12'h000;
		ok = 1'b0;
		for (n = 0; n < 400 && txd !== 1'b0; n++) @(posedge mclk);
		if (txd === 1'b0) begin
			ok = 1'b1;
			repeat (HB) @(posedge mclk);
			for (int i = 0; i < 12; i++) begin
				repeat (2 * HB) @(posedge mclk);
				f[i] = txd;
			end
		end
	endtask : getc
endmodule : scm_remote_model
`default_nettype wire

// ---- dv/scm_channel_tb.sv ----
// Self-checking bench of the serial channel: registers, framing and channel modes.
`timescale 1ns/1ps
`default_nettype none
module scm_channel_tb;
	import scm_pkg::*;
	localparam int HB = 2;
	logic        mclk = 1'b0;
	logic        arst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        iackPin = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [5:0]  inPins = 6'h00;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rxdPin;
	logic        txdPin;
	logic        outZeroN;
	logic        outFourN;
	logic        irqN;
	logic [15:0] timerPreload;
	logic [7:0]  intVector;
	int          err_total = 0;
	int          n_checks = 0;
	always #50 mclk = ~mclk;
	scm_channel #(.HALF_BIT_CYC(HB)) i_dut (
		.mclk, .arst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .rxdPin, .inPins, .iackPin, .txdPin, .outZeroN, .outFourN, .irqN,
		.timerPreload, .intVector
	);
	scm_remote_model #(.HB(HB)) i_rem (.mclk, .rxd(rxdPin), .txd(txdPin));
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results
	task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] x);
		n_checks++;
		if (s !== x) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, x, s);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] r, output logic e);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			err_total++;
			results();
		end
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		logic       e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] r);
		logic e;
		apb(1'b0, a, 8'h00, r, e);
	endtask : rd
	// Disables both directions before touching the mode registers.
	task automatic mode(input logic [7:0] c, input logic [7:0] m1, input logic [7:0] m2);
		wr(ADDR_CMD, 8'h1a);
		wr(ADDR_MODE, m1);
		wr(ADDR_MODE, m2);
		wr(ADDR_CMD, c);
	endtask : mode
	initial begin
		logic [7:0]  r;
		logic [7:0]  d;
		logic        e;
		logic        ok;
		logic        t;
		logic [11:0] f;
		logic [11:0] x;
		int          m;
		repeat (5) @(posedge mclk);
		arst_n <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			rd(ADDR_INT_MASK + 8'(4 * i), r);
			chk("reset value", r, 8'h00);
		end
		wr(ADDR_PRELOAD_UP, 8'ha5);
		wr(ADDR_PRELOAD_LO, 8'h3c);
		wr(ADDR_VECTOR, 8'h5a);
		rd(ADDR_PRELOAD_LO, r);
		chk("preload lower", r, 8'h3c);
		chk("preload", timerPreload, 16'ha53c);
		chk("vector", intVector, 8'h5a);
		apb(1'b0, 8'h30, 8'h00, r, e);
		chk("unmapped", {e, r}, 9'h100);
		apb(1'b1, ADDR_INPUT, 8'hff, r, e);
		chk("read-only write", e, 1'b1);
		for (int i = 0; i < 4; i++) begin
			iackPin <= i[0];
			inPins <= i[1] ? 6'h2a : 6'h15;
			repeat (4) @(posedge mclk);
			rd(ADDR_INPUT, r);
			chk("input port", r, {1'b1, i[0], (i[1] ? 6'h2a : 6'h15)});
		end
		inPins <= 6'h00;
		wr(ADDR_MODE, 8'h13);
		wr(ADDR_MODE, 8'h0c);
		rd(ADDR_MODE, r);
		chk("second access", r, 8'h0c);
		rd(ADDR_MODE, r);
		chk("third access", r, 8'h0c);
		wr(ADDR_CMD, 8'h10);
		rd(ADDR_MODE, r);
		chk("pointer reset", r, 8'h13);
		rd(ADDR_MODE, r);
		chk("after read", r, 8'h0c);
		$display("register test done");
		for (int p = 0; p < 4; p++) begin
			t = ~p[0];
			d = 8'hb5 ^ 8'(p);
			mode(8'h04, {3'b000, p[1:0], t, p[1:0]}, {4'h0, p[1:0], 2'b00});
			fork
				i_rem.getc(f, ok);
				wr(ADDR_DATA, d);
			join
			x = 12'(d & 8'((1 << (5 + p)) - 1));
			m = 5 + p + ((p != 2) ? 1 : 0);
			if (p != 2) x[5 + p] = (p == 0) ? (^x ^ t) : t;
			x[m] = 1'b1;
			chk("frame", {ok, f & 12'((1 << (m + 1)) - 1)}, {1'b1, x});
		end
		wr(ADDR_INT_MASK, 8'h01);
		repeat (4) @(negedge mclk);
		chk("irq allowed", irqN, 1'b0);
		wr(ADDR_INT_MASK, 8'h00);
		repeat (6) @(negedge mclk);
		chk("irq masked", irqN, 1'b1);
		wr(ADDR_OUT_PORT, 8'h11);
		wr(ADDR_OUT_CFG, 8'h10);
		repeat (2) @(negedge mclk);
		chk("out pins", {outZeroN, outFourN}, 2'b01);
		$display("transmit test done");
		mode(8'h04, 8'h13, 8'h10);
		inPins <= 6'h01;
		wr(ADDR_DATA, 8'h5c);
		i_rem.getc(f, ok);
		chk("held by gate", ok, 1'b0);
		wr(ADDR_CMD, 8'h08);
		rd(ADDR_STATUS, r);
		chk("flags off", r[3:2], 2'b00);
		fork
			i_rem.getc(f, ok);
			begin
				repeat (4) @(posedge mclk);
				inPins <= 6'h00;
			end
		join
		chk("sent after disable", {ok, f[8:0]}, {1'b1, 9'h15c});
		rd(ADDR_STATUS, r);
		chk("flags idle", r[3:2], 2'b00);
		$display("gating test done");
		mode(8'h05, 8'h13, 8'h80);
		fork
			i_rem.getc(f, ok);
			wr(ADDR_DATA, 8'h69);
		join
		chk("line held", ok, 1'b0);
		rd(ADDR_STATUS, r);
		chk("looped ready", r[0], 1'b1);
		rd(ADDR_DATA, r);
		chk("looped data", r, 8'h69);
		mode(8'h05, 8'h13, 8'h40);
		rd(ADDR_STATUS, r);
		chk("echo flags", r[3:2], 2'b00);
		fork
			i_rem.send(8'hc3, 8);
			i_rem.getc(f, ok);
		join
		chk("echoed", {ok, f[8:0]}, {1'b1, 9'h1c3});
		rd(ADDR_DATA, r);
		chk("echo received", r, 8'hc3);
		mode(8'h01, 8'h13, 8'hc0);
		fork
			i_rem.send(8'h3a, 8);
			i_rem.getc(f, ok);
		join
		chk("remote echoed", {ok, f[8:0]}, {1'b1, 9'h13a});
		rd(ADDR_STATUS, r);
		chk("remote unread", r[0], 1'b0);
		$display("mode test done");
		results();
	end
endmodule : scm_channel_tb
`default_nettype wire
